// file: core/sbrw_pkg.sv
// sbrw_pkg: constants, register map, field layouts and types of the staged watchdog.
// assumes a 10 MHz core clock and a plain one-cycle register port.
package sbrw_pkg;

    // clock and time base
    localparam int unsigned CLK_PERIOD_NS  = 100;
    localparam int unsigned SEC_NS         = 1000000000;
    localparam logic [23:0] SEC_CYCLES_DEF = 24'(SEC_NS / CLK_PERIOD_NS);

    // register byte offsets
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_STAGE   = 8'h04;
    localparam logic [7:0] OFS_SERVICE = 8'h08;
    localparam logic [7:0] OFS_STATUS  = 8'h0C;
    localparam logic [7:0] OFS_MASK    = 8'h10;
    localparam logic [7:0] OFS_STATE   = 8'h14;

    // reset values
    localparam logic [10:0] CTRL_RST  = 11'h018;
    localparam logic [17:0] STAGE_RST = 18'h00000;
    localparam logic [4:0]  MASK_RST  = 5'h00;

    // status and mask bit positions
    localparam int unsigned ST_BOOT_EXP = 0;
    localparam int unsigned ST_STAGE0   = 1;
    localparam int unsigned ST_ARMED    = 4;
    localparam int unsigned ST_W        = 5;

    // timeout tables in seconds
    localparam logic [10:0] BOOT_SEC  [7]  = '{11'd0, 11'd30, 11'd60, 11'd120, 11'd300,
                                               11'd600, 11'd1800};
    localparam logic [10:0] DELAY_SEC [8]  = '{11'd0, 11'd10, 11'd30, 11'd60, 11'd120,
                                               11'd300, 11'd600, 11'd1800};
    localparam logic [10:0] STAGE_SEC [10] = '{11'd1, 11'd2, 11'd5, 11'd10, 11'd30,
                                               11'd60, 11'd120, 11'd300, 11'd600, 11'd1800};

    typedef enum logic [1:0] {
        RT_MODE_OFF,
        RT_MODE_FIRST_SERVICE,
        RT_MODE_SINGLE,
        RT_MODE_REPEAT
    } sbrw_rt_mode_t;

    typedef enum logic [1:0] {
        EV_NONE,
        EV_OS,
        EV_RESET,
        EV_PWR
    } sbrw_ev_t;

    typedef enum logic [1:0] {
        RT_IDLE,
        RT_DELAY,
        RT_RUN
    } sbrw_rt_state_t;

    // control word, 11 bits in the low end of CTRL
    typedef struct packed {
        logic [2:0]    delay_sel;
        logic          notify_restart;
        sbrw_rt_mode_t rt_mode;
        logic          stop_pwd;
        logic          stop_user;
        logic [2:0]    boot_sel;
    } sbrw_ctrl_t;

    // stage word, 18 bits in the low end of STAGE
    typedef struct packed {
        logic [3:0] to3;
        logic [3:0] to2;
        logic [3:0] to1;
        logic [1:0] ev3;
        logic [1:0] ev2;
        logic [1:0] ev1;
    } sbrw_stage_t;

    // register port request
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } sbrw_bus_req_t;

endpackage : sbrw_pkg

// file: core/sbrw_core.sv
// sbrw_core: boot-phase watchdog and three-stage runtime watchdog with register port.
// assumes firmware status pins are asynchronous, the register port is on core_clk,
// and the event outputs are pulses consumed by platform reset and power logic.
//
// Behaviour
// RULE1: boot watchdog timeout is off, 30s, 1, 2, 5, 10 or 30 min; off by default.
// RULE2: boot watchdog counts only during self-test and resets the system on expiry.
// RULE3: with user stop set, boot count halts during boot menu or password wait.
// RULE4: with password stop set, boot count halts while password entry is pending.
// RULE5: first-service mode turns the runtime watchdog off at the first service.
// RULE6: single-pass mode runs each stage once, then turns itself off.
// RULE7: repeating mode re-fires the last stage each timeout until system reset.
// RULE8: runtime watchdog is off by default and starts just before the os boots.
// RULE9: a start delay of none, 10s, 30s, 1, 2, 5, 10 or 30 min precedes arming.
// RULE10: stage one always fires an os notice, reset or power-button event.
// RULE11: stages two and three are off or fire os notice, reset or power button.
// RULE12: each stage has its own timeout from 1s to 30 min.
// RULE13: the os notice asks for either shutdown or restart.
// RULE14: a shutdown notice is signalled as an over-temperature condition.
// RULE15: a restart notice is signalled as a fatal platform error.
// RULE16: each service restarts timing from stage one.
// RULE17: an unserviced stage timeout fires its event and starts the next enabled stage.
//
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module sbrw_core
    import sbrw_pkg::*;
#(
    parameter logic [23:0] SEC_CYCLES = sbrw_pkg::SEC_CYCLES_DEF
) (
    // clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  srst,
    // register port
    input  wire sbrw_pkg::sbrw_bus_req_t bus_req,
    output logic [31:0]                rd_data,
    // firmware status pins
    input  wire logic                  boot_self_test_phase,
    input  wire logic                  boot_menu_shown,
    input  wire logic                  setup_pwd_wait,
    input  wire logic                  pwd_entry_pending,
    input  wire logic                  os_boot_start,
    // platform events
    output logic                       sys_reset_req,
    output logic                       pwr_button_req,
    output logic                       os_overtemp_notify,
    output logic                       os_fatal_error_notify,
    output logic                       irq
);
    import sbrw_pkg::*;

    localparam int unsigned NPIN = 5;

    // decode a stage's configured event; stage one cannot be off
    function automatic sbrw_ev_t stage_event(input logic [1:0] idx, input sbrw_stage_t cfg);
        sbrw_ev_t ev;
        ev = EV_NONE;
        case (idx)
            2'd0: begin
                ev = (cfg.ev1 == 2'h1) ? EV_RESET :
                     (cfg.ev1 == 2'h2) ? EV_PWR : EV_OS;
            end
            2'd1: ev = sbrw_ev_t'(cfg.ev2);
            2'd2: ev = sbrw_ev_t'(cfg.ev3);
            default: ev = EV_NONE;
        endcase
        return ev;
    endfunction : stage_event

    // timeout of a stage in seconds; out-of-range selectors clamp to the longest
    function automatic logic [10:0] stage_secs(input logic [1:0] idx, input sbrw_stage_t cfg);
        logic [3:0] sel;
        sel = (idx == 2'd0) ? cfg.to1 : (idx == 2'd1) ? cfg.to2 : cfg.to3;
        if (sel > 4'd9) begin
            sel = 4'd9;
        end
        return STAGE_SEC[sel];
    endfunction : stage_secs

    // pin synchronisers
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_meta_reg;
    logic [NPIN-1:0] pin_sync_reg;
    logic            os_start_prev_reg;

    assign pin_raw = {os_boot_start, pwd_entry_pending, setup_pwd_wait,
                      boot_menu_shown, boot_self_test_phase};

    generate
        for (genvar i = 0; i < NPIN; i++) begin : g_sync
            always_ff @(posedge core_clk) begin
                if (srst) begin
                    pin_meta_reg[i] <= 1'b0;
                    pin_sync_reg[i] <= 1'b0;
                end else begin
                    pin_meta_reg[i] <= pin_raw[i];
                    pin_sync_reg[i] <= pin_meta_reg[i];
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk) begin
        if (srst) begin
            os_start_prev_reg <= 1'b0;
        end else begin
            os_start_prev_reg <= pin_sync_reg[4];
        end
    end

    // registers
    sbrw_ctrl_t      ctrl_reg;
    sbrw_stage_t     stage_reg;
    logic [ST_W-1:0] status_reg;
    logic [ST_W-1:0] mask_reg;
    logic            wr_ctrl;
    logic            wr_stage;
    logic            wr_status;
    logic            service;

    assign wr_ctrl   = bus_req.wr && (bus_req.addr == OFS_CTRL);
    assign wr_stage  = bus_req.wr && (bus_req.addr == OFS_STAGE);
    assign wr_status = bus_req.wr && (bus_req.addr == OFS_STATUS);
    assign service   = bus_req.wr && (bus_req.addr == OFS_SERVICE);

    always_ff @(posedge core_clk) begin
        if (srst) begin
            ctrl_reg  <= sbrw_ctrl_t'(CTRL_RST); // see RULE1 see RULE8
            stage_reg <= sbrw_stage_t'(STAGE_RST); // see RULE11
            mask_reg  <= MASK_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= sbrw_ctrl_t'(bus_req.wdata[10:0]);
            end
            if (wr_stage) begin
                stage_reg <= sbrw_stage_t'(bus_req.wdata[17:0]);
            end
            if (bus_req.wr && (bus_req.addr == OFS_MASK)) begin
                mask_reg <= bus_req.wdata[ST_W-1:0];
            end
        end
    end

    // boot-phase watchdog
    logic        boot_halt;
    logic        boot_run;
    logic        boot_expire;
    logic [10:0] boot_target;
    logic [23:0] boot_sub_reg;
    logic [10:0] boot_sec_reg;

    assign boot_halt   = (ctrl_reg.stop_user && (pin_sync_reg[1] || pin_sync_reg[2])) // see RULE3
                       || (ctrl_reg.stop_pwd && pin_sync_reg[3]); // see RULE4
    assign boot_target = (ctrl_reg.boot_sel > 3'd6) ? BOOT_SEC[6] : BOOT_SEC[ctrl_reg.boot_sel];
    assign boot_run    = pin_sync_reg[0] && (boot_target != 11'd0) && !boot_halt; // see RULE2
    assign boot_expire = boot_run && (boot_sub_reg == SEC_CYCLES - 24'd1)
                       && (boot_sec_reg == boot_target - 11'd1); // see RULE1

    // halting keeps the elapsed count; leaving self-test discards it
    always_ff @(posedge core_clk) begin
        if (srst) begin
            boot_sub_reg <= 24'h000000;
            boot_sec_reg <= 11'h000;
        end else if (!pin_sync_reg[0] || boot_expire) begin
            boot_sub_reg <= 24'h000000;
            boot_sec_reg <= 11'h000;
        end else if (boot_run) begin
            if (boot_sub_reg == SEC_CYCLES - 24'd1) begin
                boot_sub_reg <= 24'h000000;
                boot_sec_reg <= boot_sec_reg + 11'd1;
            end else begin
                boot_sub_reg <= boot_sub_reg + 24'd1;
            end
        end
    end

    // runtime watchdog
    sbrw_rt_state_t rt_state_reg;
    logic [1:0]     rt_stage_reg;
    logic [23:0]    rt_sub_reg;
    logic [10:0]    rt_sec_reg;
    logic [10:0]    rt_target;
    logic           rt_elapsed;
    logic           rt_expire;
    logic           rt_arm;
    logic           rt_last;
    logic [1:0]     rt_next;
    logic           os_start_edge;
    sbrw_ev_t       rt_event;

    assign os_start_edge = pin_sync_reg[4] && !os_start_prev_reg;
    assign rt_target     = (rt_state_reg == RT_DELAY) ? DELAY_SEC[ctrl_reg.delay_sel]
                                                      : stage_secs(rt_stage_reg, stage_reg); // see RULE12
    assign rt_elapsed    = (rt_sub_reg == SEC_CYCLES - 24'd1) && (rt_sec_reg == rt_target - 11'd1);
    assign rt_arm        = (rt_state_reg == RT_DELAY) && rt_elapsed; // see RULE9
    assign rt_expire     = (rt_state_reg == RT_RUN) && rt_elapsed && !service;
    assign rt_event      = stage_event(rt_stage_reg, stage_reg); // see RULE10 see RULE11

    // next enabled stage after the current one, if any
    always_comb begin
        rt_next = rt_stage_reg;
        rt_last = 1'b1;
        if (rt_stage_reg == 2'd0 && stage_event(2'd1, stage_reg) != EV_NONE) begin
            rt_next = 2'd1;
            rt_last = 1'b0;
        end else if (rt_stage_reg != 2'd2 && stage_event(2'd2, stage_reg) != EV_NONE) begin
            rt_next = 2'd2;
            rt_last = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            rt_state_reg <= RT_IDLE;
            rt_stage_reg <= 2'd0;
        end else begin
            case (rt_state_reg)
                RT_IDLE: begin
                    if (os_start_edge && ctrl_reg.rt_mode != RT_MODE_OFF) begin // see RULE8
                        rt_stage_reg <= 2'd0;
                        rt_state_reg <= (DELAY_SEC[ctrl_reg.delay_sel] == 11'd0)
                                        ? RT_RUN : RT_DELAY; // see RULE9
                    end
                end
                RT_DELAY: begin
                    if (ctrl_reg.rt_mode == RT_MODE_OFF) begin
                        rt_state_reg <= RT_IDLE;
                    end else if (service && ctrl_reg.rt_mode == RT_MODE_FIRST_SERVICE) begin
                        rt_state_reg <= RT_IDLE; // see RULE5
                    end else if (rt_arm) begin
                        rt_state_reg <= RT_RUN;
                    end
                end
                RT_RUN: begin
                    if (ctrl_reg.rt_mode == RT_MODE_OFF) begin
                        rt_state_reg <= RT_IDLE;
                    end else if (service) begin
                        rt_stage_reg <= 2'd0; // see RULE16
                        if (ctrl_reg.rt_mode == RT_MODE_FIRST_SERVICE) begin
                            rt_state_reg <= RT_IDLE; // see RULE5
                        end
                    end else if (rt_expire) begin
                        if (!rt_last) begin
                            rt_stage_reg <= rt_next; // see RULE17
                        end else if (ctrl_reg.rt_mode != RT_MODE_REPEAT) begin
                            rt_state_reg <= RT_IDLE; // see RULE6
                        end
                        // repeating mode stays on the last stage and re-times it; see RULE7
                    end
                end
                default: rt_state_reg <= RT_IDLE;
            endcase
        end
    end

    // stage timer restarts on arming, each service and each stage change
    always_ff @(posedge core_clk) begin
        if (srst) begin
            rt_sub_reg <= 24'h000000;
            rt_sec_reg <= 11'h000;
        end else if (rt_state_reg == RT_IDLE || rt_arm || rt_expire || service) begin
            rt_sub_reg <= 24'h000000; // see RULE16 see RULE17
            rt_sec_reg <= 11'h000;
        end else if (rt_sub_reg == SEC_CYCLES - 24'd1) begin
            rt_sub_reg <= 24'h000000;
            rt_sec_reg <= rt_sec_reg + 11'd1;
        end else begin
            rt_sub_reg <= rt_sub_reg + 24'd1;
        end
    end

    // event outputs, one-cycle pulses
    always_ff @(posedge core_clk) begin
        if (srst) begin
            sys_reset_req         <= 1'b0;
            pwr_button_req        <= 1'b0;
            os_overtemp_notify    <= 1'b0;
            os_fatal_error_notify <= 1'b0;
        end else begin
            sys_reset_req         <= boot_expire || (rt_expire && rt_event == EV_RESET); // see RULE2
            pwr_button_req        <= rt_expire && rt_event == EV_PWR;
            // the os cannot be restarted directly, so the notice is reworded; see RULE13
            os_overtemp_notify    <= rt_expire && rt_event == EV_OS
                                     && !ctrl_reg.notify_restart; // see RULE14
            os_fatal_error_notify <= rt_expire && rt_event == EV_OS
                                     && ctrl_reg.notify_restart; // see RULE15
        end
    end

    // sticky status, write one to clear; a same-cycle event wins over the clear
    logic [ST_W-1:0] status_set;

    always_comb begin
        status_set                           = '0;
        status_set[ST_BOOT_EXP]              = boot_expire;
        status_set[ST_STAGE0 + rt_stage_reg] = rt_expire;
        status_set[ST_ARMED]                 = rt_arm
                                             || (os_start_edge && rt_state_reg == RT_IDLE
                                                 && ctrl_reg.rt_mode != RT_MODE_OFF
                                                 && DELAY_SEC[ctrl_reg.delay_sel] == 11'd0);
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            status_reg <= '0;
        end else begin
            status_reg <= (status_reg & ~(wr_status ? bus_req.wdata[ST_W-1:0] : '0))
                        | status_set;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status_reg & mask_reg);
        end
    end

    // read data stands one cycle after the strobe only; unmapped reads return zero
    always_ff @(posedge core_clk) begin
        if (srst) begin
            rd_data <= 32'h00000000;
        end else if (bus_req.rd) begin
            case (bus_req.addr)
                OFS_CTRL:   rd_data <= {21'h000000, ctrl_reg};
                OFS_STAGE:  rd_data <= {14'h0000, stage_reg};
                OFS_STATUS: rd_data <= {27'h0000000, status_reg};
                OFS_MASK:   rd_data <= {27'h0000000, mask_reg};
                OFS_STATE:  rd_data <= {12'h000, pin_sync_reg[0], boot_halt,
                                        rt_state_reg, rt_stage_reg, 3'h0, rt_sec_reg};
                default:    rd_data <= 32'h00000000;
            endcase
        end else begin
            rd_data <= 32'h00000000;
        end
    end

endmodule : sbrw_core

`default_nettype wire

// file: sim/sbrw_core_props.sv
// sbrw_core_props: port-level checks of the staged watchdog, bound into sbrw_core.
// assumes SEC_CYCLES of at least 4 and a bench that leaves an idle cycle between strobes.
`timescale 1ns/1ps
`default_nettype none

module sbrw_core_props
    import sbrw_pkg::*;
#(
    parameter logic [23:0] SEC_CYCLES = sbrw_pkg::SEC_CYCLES_DEF
) (
    // clock and reset
    input wire logic                    core_clk,
    input wire logic                    srst,
    // register port
    input wire sbrw_pkg::sbrw_bus_req_t bus_req,
    input wire logic [31:0]             rd_data,
    // firmware pins
    input wire logic                    boot_self_test_phase,
    input wire logic                    boot_menu_shown,
    input wire logic                    setup_pwd_wait,
    input wire logic                    pwd_entry_pending,
    input wire logic                    os_boot_start,
    // platform events
    input wire logic                    sys_reset_req,
    input wire logic                    pwr_button_req,
    input wire logic                    os_overtemp_notify,
    input wire logic                    os_fatal_error_notify,
    input wire logic                    irq
);
    logic       rt_ev;
    logic [7:0] gap_cnt;

    assign rt_ev = pwr_button_req | os_overtemp_notify | os_fatal_error_notify;

    // saturating count since the last power-button or os-notice event; 8 bits is enough for short benches
    always_ff @(posedge core_clk) begin
        if (srst) begin
            gap_cnt <= 8'hFF;
        end else if (rt_ev) begin
            gap_cnt <= 8'h00;
        end else if (gap_cnt != 8'hFF) begin
            gap_cnt <= gap_cnt + 8'h01;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    sequence s_ctrl_wr;
        bus_req.wr && bus_req.addr == OFS_CTRL;
    endsequence
    sequence s_ctrl_rd;
        !bus_req.wr ##1 bus_req.rd && bus_req.addr == OFS_CTRL;
    endsequence

    property p_rd_idle;
        !bus_req.rd |=> rd_data == 32'h00000000;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not zero outside a read");
    property p_rd_unmapped;
        bus_req.rd && bus_req.addr == 8'h18 |=> rd_data == 32'h00000000;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
    property p_ctrl_echo;
        s_ctrl_wr ##1 s_ctrl_rd |=> rd_data == {21'h0, $past(bus_req.wdata[10:0], 3)};
    endproperty
    a_ctrl_echo: assert property (p_ctrl_echo) else $error("control readback wrong");
    property p_rst_pulse;
        sys_reset_req |=> !sys_reset_req;
    endproperty
    a_rst_pulse: assert property (p_rst_pulse) else $error("reset request too long");
    property p_pwr_pulse;
        $rose(pwr_button_req) |=> $fell(pwr_button_req);
    endproperty
    a_pwr_pulse: assert property (p_pwr_pulse) else $error("power event too long");
    property p_notify_excl;
        !(os_overtemp_notify && os_fatal_error_notify);
    endproperty
    a_notify_excl: assert property (p_notify_excl) else $error("two os notices");
    property p_ev_spacing;
        rt_ev |-> {16'h0000, gap_cnt} >= SEC_CYCLES - 24'h000001;
    endproperty
    a_ev_spacing: assert property (p_ev_spacing) else $error("stage events too close");
    property p_svc_quiet;
        bus_req.wr && bus_req.addr == OFS_SERVICE |=> !rt_ev [*3];
    endproperty
    a_svc_quiet: assert property (p_svc_quiet) else $error("event right after service");
    property p_irq_mask;
        bus_req.wr && bus_req.addr == OFS_MASK && bus_req.wdata[4:0] == 5'h00 |=> ##1 !irq;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("irq stays up with mask clear");
endmodule : sbrw_core_props

bind sbrw_core sbrw_core_props #(.SEC_CYCLES(SEC_CYCLES)) props_u (
    .core_clk(core_clk), .srst(srst), .bus_req(bus_req), .rd_data(rd_data),
    .boot_self_test_phase(boot_self_test_phase), .boot_menu_shown(boot_menu_shown),
    .setup_pwd_wait(setup_pwd_wait), .pwd_entry_pending(pwd_entry_pending),
    .os_boot_start(os_boot_start), .sys_reset_req(sys_reset_req),
    .pwr_button_req(pwr_button_req), .os_overtemp_notify(os_overtemp_notify),
    .os_fatal_error_notify(os_fatal_error_notify), .irq(irq)
);
`default_nettype wire

// file: sim/sbrw_fw_model.sv
// sbrw_fw_model: host firmware side, drives boot progress and os start pins.
// assumes the bench picks the phase on fw_step, changed away from the clock edge.
`timescale 1ns/1ps
`default_nettype none

module sbrw_fw_model (
    // clock
    input  wire logic       core_clk,
    // phase: 0 idle, 1 self-test, 2 menu, 3 setup wait, 4 pwd entry, 5 os boot
    input  wire logic [2:0] fw_step,
    // firmware status pins
    output var  logic       boot_self_test_phase = 1'b0,
    output var  logic       boot_menu_shown      = 1'b0,
    output var  logic       setup_pwd_wait       = 1'b0,
    output var  logic       pwd_entry_pending    = 1'b0,
    output var  logic       os_boot_start        = 1'b0
);
    // pins move only on clock edges, as a firmware gpio write would
    always @(posedge core_clk) begin
        boot_self_test_phase <= fw_step inside {3'h1, 3'h2, 3'h3, 3'h4};
        boot_menu_shown      <= fw_step == 3'h2;
        setup_pwd_wait       <= fw_step == 3'h3;
        pwd_entry_pending    <= fw_step == 3'h4;
        os_boot_start        <= fw_step == 3'h5;
    end
endmodule : sbrw_fw_model
`default_nettype wire

// file: sim/sbrw_core_tb.sv
// sbrw_core_tb: register-level tests of the staged watchdog.
// assumes SEC_CYCLES of 4, so one second lasts four core_clk cycles.
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
        n_errors++; \
        $display("[ERR] %0t got %0h exp %0h", $time, (got), (exp)); \
    end \
end

module sbrw_core_tb;
    import sbrw_pkg::*;
    localparam logic [23:0] SEC   = 24'h000004;
    localparam logic [3:0]  E_RST = 4'h1;
    localparam logic [3:0]  E_PWR = 4'h2;
    localparam logic [3:0]  E_OT  = 4'h4;
    localparam logic [3:0]  E_FE  = 4'h8;
    logic          core_clk = 1'b0;
    logic          srst     = 1'b1;
    sbrw_bus_req_t bus_req  = '0;
    logic [2:0]    fw_step  = 3'h0;
    logic [31:0]   rd_data;
    logic          st_ph, menu, spw, ppend, osb;
    logic          rst_q, pwr_q, ot_q, fe_q, irq;
    logic [3:0]    ev;
    logic [31:0]   rv;
    int            n_errors        = 0;
    int            samples_checked = 0;

    assign ev = {fe_q, ot_q, pwr_q, rst_q};
    always #50 core_clk = ~core_clk;

    sbrw_fw_model fw_u (
        .core_clk(core_clk), .fw_step(fw_step), .boot_self_test_phase(st_ph),
        .boot_menu_shown(menu), .setup_pwd_wait(spw), .pwd_entry_pending(ppend),
        .os_boot_start(osb)
    );
    sbrw_core #(.SEC_CYCLES(SEC)) dut_u (
        .core_clk(core_clk), .srst(srst), .bus_req(bus_req), .rd_data(rd_data),
        .boot_self_test_phase(st_ph), .boot_menu_shown(menu), .setup_pwd_wait(spw),
        .pwd_entry_pending(ppend), .os_boot_start(osb), .sys_reset_req(rst_q),
        .pwr_button_req(pwr_q), .os_overtemp_notify(ot_q), .os_fatal_error_notify(fe_q),
        .irq(irq)
    );

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus_req.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: 32'h00000000, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus_req.rd <= 1'b0;
        #1 rv = rd_data;
    endtask : rd

    // first pulse within lim cycles must match; exp of zero means none at all
    task automatic wait_ev(input logic [3:0] exp, input int lim);
        for (int k = 0; k < lim; k++) begin
            @(posedge core_clk);
            #1;
            if (ev !== 4'h0) break;
        end
        `CHK(ev, exp)
    endtask : wait_ev

    // irq is registered behind status and mask, so look two edges on
    task automatic chk_irq(input logic exp);
        repeat (2) @(posedge core_clk);
        #1;
        `CHK(irq, exp)
    endtask : chk_irq

    task automatic wrap_up();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : wrap_up

    initial begin
        repeat (16) @(posedge core_clk);
        srst <= 1'b0;
        rd(OFS_CTRL);
        `CHK(rv, {21'h0, CTRL_RST})
        rd(OFS_STAGE);
        `CHK(rv, 32'h00000000)
        rd(8'h18);
        `CHK(rv, 32'h00000000)
        fw_step <= 3'h1;
        wait_ev(4'h0, 150);
        wr(OFS_CTRL, 32'h00000019);
        rd(OFS_CTRL);
        `CHK(rv, 32'h00000019)
        wait_ev(4'h0, 110);
        wait_ev(E_RST, 20);
        for (int s = 2; s <= 4; s++) begin
            fw_step <= 3'(s);
            wait_ev(4'h0, 150);
        end
        wr(OFS_CTRL, 32'h00000001);
        wait_ev(E_RST, 130);
        fw_step <= 3'h0;
        wr(OFS_CTRL, 32'h00000018);
        rd(OFS_STATUS);
        `CHK(rv[0], 1'b1)
        wr(OFS_MASK, 32'h00000001);
        chk_irq(1'b1);
        wr(OFS_MASK, 32'h00000000);
        chk_irq(1'b0);
        wr(OFS_MASK, 32'h00000001);
        chk_irq(1'b1);
        wr(OFS_STATUS, 32'h00000001);
        chk_irq(1'b0);
        // single pass: os notice, power, reset, all one second
        wr(OFS_STAGE, 32'h0000002C);
        wr(OFS_CTRL, 32'h00000058);
        fw_step <= 3'h5;
        wait_ev(4'h0, 5);
        wait_ev(E_OT, 10);
        wait_ev(4'h0, 2);
        wait_ev(E_PWR, 4);
        wait_ev(4'h0, 2);
        wait_ev(E_RST, 4);
        wait_ev(4'h0, 40);
        rd(OFS_STATUS);
        `CHK(rv[3:1], 3'h7)
        // repeat mode, restart notice, 10 s delay, stage two off, stage three 2 s
        fw_step <= 3'h0;
        wr(OFS_STAGE, 32'h00004030);
        wr(OFS_CTRL, 32'h000001F8);
        fw_step <= 3'h5;
        wait_ev(4'h0, 42);
        wait_ev(E_FE, 12);
        for (int r = 0; r < 3; r++) begin
            wait_ev(4'h0, 6);
            wait_ev(E_PWR, 4);
        end
        wr(OFS_SERVICE, 32'h00000000);
        wait_ev(4'h0, 2);
        wait_ev(E_FE, 6);
        // first-service mode with a 10 s first stage
        fw_step <= 3'h0;
        wr(OFS_CTRL, 32'h00000018);
        wr(OFS_STAGE, 32'h000000C1);
        wr(OFS_CTRL, 32'h00000038);
        fw_step <= 3'h5;
        wait_ev(4'h0, 15);
        wr(OFS_SERVICE, 32'h00000000);
        wait_ev(4'h0, 200);
        rd(OFS_STATE);
        `CHK(rv[17:16], 2'h0)
        wrap_up();
    end

    // the tests need about 1,300 cycles
    initial begin
        repeat (20000) @(posedge core_clk);
        n_errors++;
        wrap_up();
    end
endmodule : sbrw_core_tb
`default_nettype wire
